// *** design/serial_config_port.sv ***
/*
  serial configuration port: 24-bit address/data words shifted in on the
  shift clock, a register file, readback on a three-state serial output.
  assumes shift clock and frame select come from outside and are oversampled
  by core_clk_i; hardware reset pin is active high and asynchronous.
*/
// Summary of operation
// [R01] shift only while frame select low
// [R02] sample serial input on shift rising edge
// [R03] every 24th edge writes addressed register
// [R04] trailing bits past last word dropped
// [R05] group counter starts at frame select fall
// [R06] word is 8-bit address, 16-bit data
// [R07] host writes zero to unused bits
// [R08] host shift clock at most 20 MHz
// [R09] host holds reset high over 100 ns
// [R10] host waits 100 ns after reset
// [R11] new value active right after word
// [R12] host sets readback enable before reading
// [R13] readback drives selected register data out
// [R14] output changes on shift falling edge
// [R15] host picks capture edge by speed
// [R16] readback enable stays writable, clear restores
// [R17] output driven only when readback enabled
// [R18] one readback device per shared wire
// [R19] soft reset bit clears all, self-clears
// [R20] hardware reset pulse zeroes all registers
// [R21] word shifted most significant bit first
// [R22] partial word dropped, counter restarts
`timescale 1ns/1ps
module serial_config_port
  import scp_pkg::*;
#(
  parameter int unsigned NUM_REGS = 256
)(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic hw_reset_i,
  input wire logic frame_select_n_i,
  input wire logic shift_clk_i,
  input wire logic serial_in_i,
  output logic serial_out_o,
  output logic serial_out_oe_o,
  output logic [NUM_REGS*DATA_BITS-1:0] regs_o
);
  initial begin
    if (NUM_REGS < 1 || NUM_REGS > (1 << ADDR_BITS)) begin
      $error("NUM_REGS out of range");
    end
  end

  link_in_s pins_raw;
  link_in_s pins;
  logic rst_s1;
  logic rst_s2;
  logic sclk_d;
  logic sclk_rise;
  logic sclk_fall;
  logic [CNT_BITS-1:0] bit_cnt;
  logic [CNT_BITS-1:0] next_bit_cnt;
  logic [WORD_BITS-2:0] shreg;
  logic [WORD_BITS-2:0] next_shreg;
  logic [DATA_BITS-1:0] regs [NUM_REGS];
  logic [DATA_BITS-1:0] next_regs [NUM_REGS];
  logic [DATA_BITS-1:0] rd_shift;
  logic [DATA_BITS-1:0] next_rd_shift;
  logic sdo;
  logic next_sdo;
  reg_wr_s wr;

  assign pins_raw = '{frame_select_n: frame_select_n_i, shift_clk: shift_clk_i,
                      serial_in: serial_in_i};

  scp_sync u_sync (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .pins_i(pins_raw),
    .pins_o(pins)
  );

  function automatic logic [DATA_BITS-1:0] reg_read(
    input logic [DATA_BITS-1:0] file [NUM_REGS],
    input logic [ADDR_BITS-1:0] a
  );
    reg_read = (int'(a) < NUM_REGS) ? file[a] : REG_RESET;
  endfunction : reg_read

  // hardware reset pin is asynchronous: sync before use
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
      sclk_d <= 1'b0;
    end else begin
      rst_s1 <= hw_reset_i;
      rst_s2 <= rst_s1;
      sclk_d <= pins.shift_clk;
    end
  end

  assign sclk_rise = pins.shift_clk && !sclk_d;
  assign sclk_fall = !pins.shift_clk && sclk_d;

  logic readout_en;
  assign readout_en = regs[CTRL_ADDR][READOUT_EN_BIT];

  always_comb begin
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    wr = '{wr_en: 1'b0, addr: '0, data: '0};
    if (pins.frame_select_n) begin
      next_bit_cnt = CNT_ZERO; // R22 R05
    end else if (sclk_rise) begin // R01 R02
      next_shreg = {shreg[WORD_BITS-3:0], pins.serial_in}; // R21
      if (bit_cnt == CNT_LAST) begin
        next_bit_cnt = CNT_ZERO; // R05
        wr.wr_en = 1'b1; // R03
        wr.addr = shreg[WORD_BITS-2 -: ADDR_BITS]; // R06
        wr.data = {shreg[DATA_BITS-2:0], pins.serial_in}; // R06
      end else begin
        next_bit_cnt = bit_cnt + 5'h01; // R04 partial group never writes
      end
    end
  end

  // register file: in readback only the control word stays writable
  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      next_regs[i] = regs[i];
    end
    if (wr.wr_en && (!readout_en || wr.addr == CTRL_ADDR)) begin // R16
      if (wr.addr == CTRL_ADDR && wr.data[SOFT_RESET_BIT]) begin
        for (int i = 0; i < NUM_REGS; i++) begin
          next_regs[i] = REG_RESET; // R19 reset bit never stored
        end
      end else if (int'(wr.addr) < NUM_REGS) begin
        next_regs[wr.addr] = wr.data; // R11
      end
    end
  end

  // readback: load on address byte, shift out on falling edges
  always_comb begin
    next_rd_shift = rd_shift;
    next_sdo = sdo;
    if (pins.frame_select_n) begin
      next_sdo = 1'b0;
    end else if (sclk_rise && bit_cnt == CNT_DATA0 - 5'h01) begin
      next_rd_shift = reg_read(regs, {shreg[ADDR_BITS-2:0], pins.serial_in}); // R13
    end else if (sclk_fall && bit_cnt >= CNT_DATA0) begin
      next_sdo = rd_shift[DATA_BITS-1]; // R14
      next_rd_shift = {rd_shift[DATA_BITS-2:0], 1'b0};
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bit_cnt <= CNT_ZERO;
      shreg <= '0;
      rd_shift <= REG_RESET;
      sdo <= 1'b0;
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= REG_RESET;
      end
    end else if (rst_s2) begin
      bit_cnt <= CNT_ZERO;
      shreg <= '0;
      rd_shift <= REG_RESET;
      sdo <= 1'b0;
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= REG_RESET; // R20
      end
    end else begin
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      rd_shift <= next_rd_shift;
      sdo <= next_sdo;
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= next_regs[i];
      end
    end
  end

  generate
    for (genvar g = 0; g < NUM_REGS; g++) begin : g_out
      assign regs_o[g*DATA_BITS +: DATA_BITS] = regs[g];
    end
  endgenerate

  // shared wire needs enable gated on readback only
  assign serial_out_oe_o = readout_en; // R17 R18
  assign serial_out_o = sdo;

  property p_no_shift_idle;
    @(posedge core_clk_i) disable iff (!rstn_i)
    pins.frame_select_n |=> bit_cnt == CNT_ZERO;
  endproperty
  a_no_shift_idle: assert property (p_no_shift_idle) // R01
    else $error("counter moved while frame select high");

  property p_count;
    @(posedge core_clk_i) disable iff (!rstn_i || rst_s2)
    (!pins.frame_select_n && sclk_rise && bit_cnt != CNT_LAST)
      |=> bit_cnt == $past(bit_cnt) + 5'h01;
  endproperty
  a_count: assert property (p_count) // R02
    else $error("bit counter did not advance on rising edge");

  property p_wrap;
    @(posedge core_clk_i) disable iff (!rstn_i || rst_s2)
    (!pins.frame_select_n && sclk_rise && bit_cnt == CNT_LAST) |=> bit_cnt == CNT_ZERO;
  endproperty
  a_wrap: assert property (p_wrap) // R05
    else $error("counter did not wrap after 24 bits");

  property p_write_only_last;
    @(posedge core_clk_i) disable iff (!rstn_i)
    wr.wr_en |-> bit_cnt == CNT_LAST && sclk_rise;
  endproperty
  a_write_only_last: assert property (p_write_only_last) // R03
    else $error("write outside 24th edge");

  property p_write_takes;
    @(posedge core_clk_i) disable iff (!rstn_i || rst_s2)
    (wr.wr_en && !readout_en && wr.addr != CTRL_ADDR && int'(wr.addr) < NUM_REGS)
      |=> regs[$past(wr.addr)] == $past(wr.data);
  endproperty
  a_write_takes: assert property (p_write_takes) // R11
    else $error("register not updated after word");

  property p_soft_reset;
    @(posedge core_clk_i) disable iff (!rstn_i || rst_s2)
    (wr.wr_en && wr.addr == CTRL_ADDR && wr.data[SOFT_RESET_BIT])
      |=> regs[CTRL_ADDR] == REG_RESET;
  endproperty
  a_soft_reset: assert property (p_soft_reset) // R19
    else $error("soft reset did not clear control");

  property p_hw_reset;
    @(posedge core_clk_i) disable iff (!rstn_i)
    rst_s2 |=> regs[CTRL_ADDR] == REG_RESET && !serial_out_oe_o;
  endproperty
  a_hw_reset: assert property (p_hw_reset) // R20
    else $error("hardware reset did not clear registers");

  property p_out_edge;
    @(posedge core_clk_i) disable iff (!rstn_i)
    (!pins.frame_select_n && $changed(sdo)) |-> $past(sclk_fall);
  endproperty
  a_out_edge: assert property (p_out_edge) // R14
    else $error("serial output changed off falling edge");

  property p_oe;
    @(posedge core_clk_i) disable iff (!rstn_i)
    serial_out_oe_o |-> regs[CTRL_ADDR][READOUT_EN_BIT];
  endproperty
  a_oe: assert property (p_oe) // R17
    else $error("output enabled without readback");

  c_write: cover property (@(posedge core_clk_i) disable iff (!rstn_i) wr.wr_en);
  c_readback: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
    serial_out_oe_o && sclk_fall);
  c_soft_rst: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
    wr.wr_en && wr.addr == CTRL_ADDR && wr.data[SOFT_RESET_BIT]);
endmodule : serial_config_port

// *** design/scp_pkg.sv ***
/*
  package for the serial configuration port: frame layout, register file
  shape, control bit positions and sampler timing.
  assumes a single core clock domain that oversamples the link pins.
*/
package scp_pkg;
  localparam int unsigned WORD_BITS = 24;
  localparam int unsigned ADDR_BITS = 8;
  localparam int unsigned DATA_BITS = 16;
  localparam int unsigned CNT_BITS = 5;
  localparam logic [CNT_BITS-1:0] CNT_LAST = 5'h17;
  localparam logic [CNT_BITS-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_BITS-1:0] CNT_DATA0 = 5'h08;
  localparam logic [ADDR_BITS-1:0] CTRL_ADDR = 8'h00;
  localparam int unsigned SOFT_RESET_BIT = 0;
  localparam int unsigned READOUT_EN_BIT = 1;
  localparam logic [DATA_BITS-1:0] REG_RESET = 16'h0000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned LINK_MIN_PERIOD_NS = 50;
  localparam int unsigned LINK_MIN_CYCLES =
    (LINK_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic frame_select_n;
    logic shift_clk;
    logic serial_in;
  } link_in_s;

  typedef struct packed {
    logic wr_en;
    logic [ADDR_BITS-1:0] addr;
    logic [DATA_BITS-1:0] data;
  } reg_wr_s;
endpackage : scp_pkg

// *** design/scp_sync.sv ***
/*
  two-flop synchroniser for a bundle of link pins.
  assumes inputs are asynchronous to core_clk_i.
*/
`timescale 1ns/1ps
module scp_sync
  import scp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire link_in_s pins_i,
  output link_in_s pins_o
);
  link_in_s stage1;
  link_in_s stage2;
  link_in_s next_stage1;
  link_in_s next_stage2;

  always_comb begin
    next_stage1 = pins_i;
    next_stage2 = stage1;
  end

  // frame select idles high so reset holds it inactive
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stage1 <= '{frame_select_n: 1'b1, shift_clk: 1'b0, serial_in: 1'b0};
      stage2 <= '{frame_select_n: 1'b1, shift_clk: 1'b0, serial_in: 1'b0};
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign pins_o = stage2;
endmodule : scp_sync

// *** verif/scp_host.sv ***
/*
  host controller model driving the serial link of the config port.
  assumes clk_i is the bench core clock; pins move on its falling edge.
*/
`timescale 1ns/1ps
module scp_host (
  input wire logic clk_i,
  input wire logic serial_out_i,
  output logic frame_select_n_o,
  output logic shift_clk_o,
  output logic serial_in_o
);
  initial begin
    frame_select_n_o = 1'b1;
    shift_clk_o = 1'b0;
    serial_in_o = 1'b0;
  end

  // 30 ns high, 50 ns low: uneven duty, still an 80 ns period
  task automatic xfer(input logic [63:0] w, input int n, output logic [15:0] rd);
    rd = 16'h0000;
    @(negedge clk_i);
    frame_select_n_o = 1'b0;
    for (int k = 1; k <= n; k++) begin
      serial_in_o = w[n-k];
      repeat (5) @(negedge clk_i);
      // d15 appears after the 8th fall, so the 9th rise takes it
      if (k >= 9 && k <= 24) rd[24-k] = serial_out_i;
      shift_clk_o = 1'b1;
      repeat (3) @(negedge clk_i);
      shift_clk_o = 1'b0;
    end
    repeat (5) @(negedge clk_i);
    frame_select_n_o = 1'b1;
    // released line must not keep its last value
    serial_in_o = ~serial_in_o;
    repeat (8) @(negedge clk_i);
  endtask : xfer

  // clock pulses with the frame deselected, only when the bench asks
  task automatic stray(input int n);
    repeat (n) begin
      @(negedge clk_i);
      shift_clk_o = 1'b1;
      serial_in_o = ~serial_in_o;
      repeat (3) @(negedge clk_i);
      shift_clk_o = 1'b0;
      repeat (5) @(negedge clk_i);
    end
  endtask : stray
endmodule : scp_host

// *** verif/serial_config_port_test.sv ***
/*
  self-checking bench for the serial configuration port.
  assumes scp_host as the far-side controller and the default register count.
*/
`timescale 1ns/1ps
module serial_config_port_test;
  import scp_pkg::*;
  logic core_clk_i;
  logic rstn_i;
  logic hw_reset_i;
  logic frame_select_n;
  logic shift_clk;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe;
  logic [256*DATA_BITS-1:0] regs;
  logic [15:0] rd;
  int bad_count = 0;
  int comparisons = 0;

  serial_config_port DUT (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .hw_reset_i(hw_reset_i),
    .frame_select_n_i(frame_select_n), .shift_clk_i(shift_clk), .serial_in_i(serial_in),
    .serial_out_o(serial_out), .serial_out_oe_o(serial_out_oe), .regs_o(regs));
  scp_host HOST (.clk_i(core_clk_i), .serial_out_i(serial_out),
    .frame_select_n_o(frame_select_n), .shift_clk_o(shift_clk), .serial_in_o(serial_in));

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [15:0] reg_at(input int a);
    return regs[16*a +: 16];
  endfunction : reg_at

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    HOST.xfer(64'({a, d}), 24, rd);
  endtask : wr

  task automatic t_all_zero(input string what);
    check(what, {15'h0000, |regs}, 16'h0000);
  endtask : t_all_zero

  task automatic t_multi;
    // two words and five leftover bits in one frame
    HOST.xfer({11'h000, 8'h05, 16'hA5C3, 8'hFF, 16'h1234, 5'h15}, 53, rd);
    check("reg 05", reg_at(5), 16'hA5C3);
    check("reg ff", reg_at(255), 16'h1234);
    check("reg 00", reg_at(0), 16'h0000);
  endtask : t_multi

  task automatic t_partial;
    HOST.xfer(64'({8'h07, 12'hFFF}), 20, rd);
    check("reg 07 partial", reg_at(7), 16'h0000);
    HOST.stray(7);
    wr(8'h07, 16'h00F0);
    check("reg 07 aligned", reg_at(7), 16'h00F0);
  endtask : t_partial

  task automatic t_readback;
    check("oe idle", {15'h0000, serial_out_oe}, 16'h0000);
    wr(8'h00, 16'h0002);
    check("oe on", {15'h0000, serial_out_oe}, 16'h0001);
    wr(8'h05, 16'h0000);
    check("readback 05", rd, 16'hA5C3);
    check("reg 05 kept", reg_at(5), 16'hA5C3);
    wr(8'h09, 16'h5555);
    check("reg 09 blocked", reg_at(9), 16'h0000);
    wr(8'h00, 16'h0000);
    check("oe off", {15'h0000, serial_out_oe}, 16'h0000);
  endtask : t_readback

  task automatic t_soft;
    wr(8'h00, 16'h0001);
    t_all_zero("soft reset");
  endtask : t_soft

  task automatic t_hw;
    wr(8'h05, 16'h0F0F);
    check("reg 05 set", reg_at(5), 16'h0F0F);
    hw_reset_i = 1'b1;
    repeat (12) @(negedge core_clk_i);
    hw_reset_i = 1'b0;
    repeat (12) @(negedge core_clk_i);
    t_all_zero("hw reset");
  endtask : t_hw

  initial begin
    #400_000;
    bad_count++;
    close_out();
  end

  initial begin
    rstn_i = 1'b0;
    hw_reset_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    rstn_i = 1'b1;
    repeat (6) @(negedge core_clk_i);
    t_all_zero("after reset");
    t_multi();
    t_partial();
    t_readback();
    t_soft();
    t_multi();
    t_hw();
    close_out();
  end
endmodule : serial_config_port_test
